//--- core/mcb_pkg.sv
// package: constants for the memory clock output and host pin strap block
package mcb_pkg;

  // avalon register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL2 = 8'h00;
  localparam logic [7:0] ADDR_XBUS = 8'h04;
  localparam logic [7:0] ADDR_GDIR = 8'h08;
  localparam logic [7:0] ADDR_GOUT = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_HRX = 8'h14;
  localparam logic [7:0] ADDR_HTX = 8'h18;

  // memory_global_control_two fields
  localparam int CTRL2_MODE_LSB = 0;
  localparam int CTRL2_DIV_LSB = 2;

  // drive modes of the second memory clock output
  typedef enum logic [1:0] {
    MCB_MODE_HOLD = 2'h0,
    MCB_MODE_TOGGLE = 2'h1,
    MCB_MODE_HIZ = 2'h2
  } mcb_mode_t;

  // divide factors 1, 2, 4
  typedef enum logic [1:0] {
    MCB_DIV1 = 2'h0,
    MCB_DIV2 = 2'h1,
    MCB_DIV4 = 2'h2
  } mcb_div_t;

  // status register bit positions
  localparam int STAT_HOST_MODE = 0;
  localparam int STAT_SRC_EXT = 1;
  localparam int STAT_HALF = 2;
  localparam int STAT_PINS_LSB = 8;

  // reset values
  localparam logic [7:0] XBUS_RESET = 8'hff;
  localparam logic [7:0] GDIR_RESET = 8'h00;
  localparam logic [7:0] GOUT_RESET = 8'h00;
  localparam logic [15:0] HTX_RESET = 16'h0000;

  // avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

endpackage : mcb_pkg

//--- core/mcb_clk_div.sv
// module: glitch-free divider for the second memory clock output
`timescale 1ns/1ps
`default_nettype none
module mcb_clk_div (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic rise_i,
  input wire logic fall_i,
  input wire mcb_pkg::mcb_mode_t mode_i,
  input wire mcb_pkg::mcb_div_t div_i,
  output logic clk_o,
  output logic oe_n_o
);

  // no reset on these: the output has to keep toggling while reset_i is high
  mcb_pkg::mcb_mode_t act_mode_q = mcb_pkg::MCB_MODE_HOLD;
  mcb_pkg::mcb_div_t act_div_q = mcb_pkg::MCB_DIV4;
  logic out_q = 1'b0;
  logic skip_q = 1'b0;

  wire mcb_pkg::mcb_mode_t req_mode;
  wire mcb_pkg::mcb_div_t req_div;
  wire load;
  wire mcb_pkg::mcb_mode_t cur_mode;
  wire mcb_pkg::mcb_div_t cur_div;

  // during reset the pin runs at a quarter of the source clock
  assign req_mode = reset_i ? mcb_pkg::MCB_MODE_TOGGLE : mode_i; // [RULE_03]
  assign req_div = reset_i ? mcb_pkg::MCB_DIV4 : div_i; // [RULE_03]
  // new settings only at a rise with the output low and a period complete
  assign load = rise_i && !out_q && !skip_q; // [RULE_16]
  assign cur_mode = load ? req_mode : act_mode_q;
  assign cur_div = load ? req_div : act_div_q;

  always_ff @(posedge clk_i) begin
    if (load) begin
      act_mode_q <= req_mode;
      act_div_q <= req_div;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rise_i) begin
      if (cur_mode != mcb_pkg::MCB_MODE_TOGGLE) begin
        out_q <= 1'b0; // [RULE_02]
        skip_q <= 1'b0;
      end else if (load) begin
        out_q <= 1'b1; // [RULE_01]
        skip_q <= (cur_div == mcb_pkg::MCB_DIV4);
      end else if (cur_div == mcb_pkg::MCB_DIV2) begin
        out_q <= ~out_q; // [RULE_01]
      end else if (cur_div == mcb_pkg::MCB_DIV4) begin
        if (skip_q) begin
          skip_q <= 1'b0;
        end else begin
          out_q <= ~out_q; // [RULE_01]
          skip_q <= 1'b1;
        end
      end
    end else if (fall_i && act_div_q == mcb_pkg::MCB_DIV1) begin
      out_q <= 1'b0; // [RULE_01]
    end
  end

  always_ff @(posedge clk_i) begin
    oe_n_o <= (cur_mode == mcb_pkg::MCB_MODE_HIZ) && !reset_i; // [RULE_02]
    clk_o <= out_q;
  end

endmodule : mcb_clk_div
`default_nettype wire

//--- core/mcb_pin_strap.sv
// module: memory clock output, clock source select and host pin strap logic
//
// Overview of operation
// RULE_01: clock out divides selected source by 1/2/4
// RULE_02: clock out may be held low or floated
// RULE_03: during reset clock out runs at quarter rate
// RULE_04: strap 0 and select 0: held low
// RULE_05: select 1: quarter of external memory clock
// RULE_06: strap 1, select 0: quarter of system clock
// RULE_07: select low system clock, high external clock
// RULE_08: strap low gpio, strap high host bus
// RULE_09: pin function latched at reset release
// RULE_10: holders keep last driven level when floating
// RULE_11: holders on after reset, switchable per pin
// RULE_12: gpio bits are inputs after reset
// RULE_13: host data lines are inputs after reset
// RULE_14: strap high selects multiplexed host mode
// RULE_15: host cycle is two consecutive byte transfers
// RULE_16: setting changes never produce runt pulses
`timescale 1ns/1ps
`default_nettype none
module mcb_pin_strap #(
  parameter int HD_W = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic internal_system_clock_i,
  input wire logic external_memory_clock_in_i,
  input wire logic memory_clock_source_select_i,
  input wire logic boot_strap_pin_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  output logic memory_clock_out_b_o,
  output logic memory_clock_out_b_oe_n_o,
  output logic memory_interface_clock_o,
  output logic memory_clock_source_ext_o,
  input wire logic [HD_W-1:0] host_port_data_pins_i,
  output logic [HD_W-1:0] host_port_data_pins_o,
  output logic [HD_W-1:0] host_port_data_pins_oe_n_o,
  output logic [HD_W-1:0] bus_holder_en_o,
  output logic [HD_W-1:0] bus_holder_level_o,
  input wire logic host_strobe_i,
  input wire logic host_read_i,
  output logic host_mode_o,
  output logic host_word_valid_o,
  output logic [15:0] host_word_o
);

  if (HD_W != 8) begin : g_width_check
    $error("mcb_pin_strap: host data width must be 8");
  end

  // byte-lane merge, used by every writable register
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic rising(input logic now_v, input logic was_v);
    return now_v && !was_v;
  endfunction : rising

  // ---------------- pin synchronisers ----------------
  localparam int SW = HD_W + 6;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  wire [SW-1:0] pins_raw;

  assign pins_raw = {host_port_data_pins_i, host_read_i, host_strobe_i, boot_strap_pin_i,
                     memory_clock_source_select_i, external_memory_clock_in_i, internal_system_clock_i};

  // data path only: left without reset so the strap is seen while reset is high
  always_ff @(posedge clk_i) begin
    sync1_q <= pins_raw;
    sync2_q <= sync1_q;
  end

  wire sys_s;
  wire ext_s;
  wire sel_s;
  wire strap_s;
  wire strobe_s;
  wire hread_s;
  wire [HD_W-1:0] hd_s;

  assign sys_s = sync2_q[0];
  assign ext_s = sync2_q[1];
  assign sel_s = sync2_q[2];
  assign strap_s = sync2_q[3];
  assign strobe_s = sync2_q[4];
  assign hread_s = sync2_q[5];
  assign hd_s = sync2_q[SW-1:6];

  // ---------------- clock source selection ----------------
  wire src_lvl;
  logic src_prev_q;
  logic strobe_prev_q;
  wire src_rise;
  wire src_fall;
  wire strobe_rise;

  // the sampled source only works for source clocks below a quarter of clk_i
  assign src_lvl = sel_s ? ext_s : sys_s; // [RULE_07]
  assign src_rise = rising(src_lvl, src_prev_q);
  assign src_fall = rising(src_prev_q, src_lvl);
  assign strobe_rise = rising(strobe_s, strobe_prev_q);

  always_ff @(posedge clk_i) begin
    src_prev_q <= src_lvl;
    strobe_prev_q <= strobe_s;
  end

  always_ff @(posedge clk_i) begin
    memory_interface_clock_o <= src_lvl; // [RULE_07]
    memory_clock_source_ext_o <= sel_s; // [RULE_07]
  end

  // ---------------- strap capture ----------------
  logic strap_q;

  // the strap is followed all through reset and frozen when reset drops
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      strap_q <= strap_s; // [RULE_09]
    end
  end

  wire host_mode;
  assign host_mode = strap_q; // [RULE_08] [RULE_14]

  // ---------------- registers ----------------
  mcb_pkg::mcb_mode_t mode_q;
  mcb_pkg::mcb_div_t div_q;
  logic [HD_W-1:0] xbus_q;
  logic [HD_W-1:0] gdir_q;
  logic [HD_W-1:0] gout_q;
  logic [15:0] htx_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;

  wire req;
  wire accept;
  wire do_write;
  wire hit_ctrl2;
  wire hit_xbus;
  wire hit_gdir;
  wire hit_gout;
  wire hit_stat;
  wire hit_hrx;
  wire hit_htx;
  wire mapped;
  wire [31:0] ctrl2_word;
  wire [31:0] stat_word;
  wire [31:0] rd_mux;
  wire [31:0] ctrl2_new;
  wire [31:0] xbus_new;
  wire [31:0] gdir_new;
  wire [31:0] gout_new;
  wire [31:0] htx_new;
  wire mcb_pkg::mcb_mode_t mode_after_reset;
  logic half_q;
  logic [HD_W-1:0] rx_lo_q;
  logic [15:0] hword_q;

  assign req = avs_read_i || avs_write_i;
  // first cycle of a request prepares the answer, second completes it
  assign accept = req && !wait_q;
  assign do_write = accept && avs_write_i;

  assign hit_ctrl2 = avs_address_i == mcb_pkg::ADDR_CTRL2;
  assign hit_xbus = avs_address_i == mcb_pkg::ADDR_XBUS;
  assign hit_gdir = avs_address_i == mcb_pkg::ADDR_GDIR;
  assign hit_gout = avs_address_i == mcb_pkg::ADDR_GOUT;
  assign hit_stat = avs_address_i == mcb_pkg::ADDR_STAT;
  assign hit_hrx = avs_address_i == mcb_pkg::ADDR_HRX;
  assign hit_htx = avs_address_i == mcb_pkg::ADDR_HTX;
  assign mapped = hit_ctrl2 || hit_xbus || hit_gdir || hit_gout || hit_stat || hit_hrx || hit_htx;

  assign ctrl2_word = {28'h0000000, div_q, mode_q};
  assign stat_word = {16'h0000, hd_s, 5'h00, half_q, sel_s, host_mode};
  assign rd_mux = hit_ctrl2 ? ctrl2_word :
                  hit_xbus ? {24'h000000, xbus_q} :
                  hit_gdir ? {24'h000000, gdir_q} :
                  hit_gout ? {24'h000000, gout_q} :
                  hit_stat ? stat_word :
                  hit_hrx ? {16'h0000, hword_q} :
                  hit_htx ? {16'h0000, htx_q} : 32'h00000000;

  assign ctrl2_new = be_merge(ctrl2_word, avs_writedata_i, avs_byteenable_i);
  assign xbus_new = be_merge({24'h000000, xbus_q}, avs_writedata_i, avs_byteenable_i);
  assign gdir_new = be_merge({24'h000000, gdir_q}, avs_writedata_i, avs_byteenable_i);
  assign gout_new = be_merge({24'h000000, gout_q}, avs_writedata_i, avs_byteenable_i);
  assign htx_new = be_merge({16'h0000, htx_q}, avs_writedata_i, avs_byteenable_i);

  // after reset: held low only when both the strap and the select are 0
  assign mode_after_reset = (strap_s || sel_s) ? mcb_pkg::MCB_MODE_TOGGLE
                                               : mcb_pkg::MCB_MODE_HOLD; // [RULE_04] [RULE_05] [RULE_06]

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
      resp_q <= mcb_pkg::RESP_OKAY;
    end else begin
      wait_q <= !(req && wait_q);
      if (req && wait_q) begin
        rdata_q <= avs_read_i ? rd_mux : 32'h00000000;
        resp_q <= mapped ? mcb_pkg::RESP_OKAY : mcb_pkg::RESP_SLVERR;
      end
    end
  end

  // divide by 4 from any source after reset; strap and select together decide only on/off
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_q <= mode_after_reset; // [RULE_04] [RULE_05] [RULE_06]
      div_q <= mcb_pkg::MCB_DIV4; // [RULE_05] [RULE_06]
    end else if (do_write && hit_ctrl2) begin
      mode_q <= mcb_pkg::mcb_mode_t'(ctrl2_new[mcb_pkg::CTRL2_MODE_LSB +: 2]); // [RULE_02]
      div_q <= mcb_pkg::mcb_div_t'(ctrl2_new[mcb_pkg::CTRL2_DIV_LSB +: 2]); // [RULE_01]
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      xbus_q <= mcb_pkg::XBUS_RESET; // [RULE_11]
      gdir_q <= mcb_pkg::GDIR_RESET; // [RULE_12]
      gout_q <= mcb_pkg::GOUT_RESET;
      htx_q <= mcb_pkg::HTX_RESET;
    end else if (do_write) begin
      if (hit_xbus) begin
        xbus_q <= xbus_new[HD_W-1:0]; // [RULE_11]
      end
      if (hit_gdir) begin
        gdir_q <= gdir_new[HD_W-1:0];
      end
      if (hit_gout) begin
        gout_q <= gout_new[HD_W-1:0];
      end
      if (hit_htx) begin
        htx_q <= htx_new[15:0];
      end
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign avs_response_o = resp_q;

  // ---------------- second memory clock output ----------------
  mcb_clk_div u_div (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .rise_i(src_rise),
    .fall_i(src_fall),
    .mode_i(mode_q),
    .div_i(div_q),
    .clk_o(memory_clock_out_b_o),
    .oe_n_o(memory_clock_out_b_oe_n_o)
  );

  // ---------------- host transfers ----------------
  logic hvalid_q;

  // a host cycle is two strobed bytes, first byte goes to the low half
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      half_q <= 1'b0;
      rx_lo_q <= '0;
      hword_q <= 16'h0000;
      hvalid_q <= 1'b0;
    end else begin
      hvalid_q <= 1'b0;
      if (host_mode && strobe_rise) begin
        if (!half_q) begin
          rx_lo_q <= hd_s; // [RULE_15]
          half_q <= 1'b1;
        end else begin
          hword_q <= {hd_s, rx_lo_q}; // [RULE_15]
          hvalid_q <= 1'b1;
          half_q <= 1'b0;
        end
      end
    end
  end

  assign host_word_o = hword_q;
  assign host_word_valid_o = hvalid_q;

  // ---------------- data pin drivers ----------------
  logic [HD_W-1:0] hd_out_q;
  logic [HD_W-1:0] hd_oe_n_q;
  logic [HD_W-1:0] hold_q;
  logic hmode_q;
  wire [HD_W-1:0] host_byte;
  wire [HD_W-1:0] next_out;
  wire [HD_W-1:0] next_oe_n;

  // the host reads the word back in the same two-byte order it writes
  assign host_byte = half_q ? htx_q[15:8] : htx_q[7:0]; // [RULE_15]
  assign next_out = host_mode ? host_byte : gout_q; // [RULE_08]
  // gpio follows its direction register, the host bus drives only on a host read
  assign next_oe_n = host_mode ? {HD_W{!hread_s}} : ~gdir_q; // [RULE_12] [RULE_13]

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hd_out_q <= '0;
      hd_oe_n_q <= '1; // [RULE_12] [RULE_13]
      hmode_q <= 1'b0;
    end else begin
      hd_out_q <= next_out;
      hd_oe_n_q <= next_oe_n;
      hmode_q <= host_mode; // [RULE_09]
    end
  end

  // tracks the last level seen on each pin: own drive when driving, else the pin
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < HD_W; i++) begin
      hold_q[i] <= hd_oe_n_q[i] ? hd_s[i] : hd_out_q[i]; // [RULE_10]
    end
  end

  assign host_port_data_pins_o = hd_out_q;
  assign host_port_data_pins_oe_n_o = hd_oe_n_q;
  assign bus_holder_en_o = xbus_q; // [RULE_11]
  assign bus_holder_level_o = hold_q; // [RULE_10]
  assign host_mode_o = hmode_q;

endmodule : mcb_pin_strap
`default_nettype wire

//--- tb/mcb_pin_strap_properties.sv
// checker: port-level timing relations of the memory clock and host pin strap block
`timescale 1ns/1ps
`default_nettype none
module mcb_pin_strap_properties #(
  parameter int HD_W = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic internal_system_clock_i,
  input wire logic external_memory_clock_in_i,
  input wire logic memory_clock_source_select_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  input wire logic memory_clock_out_b_o,
  input wire logic memory_clock_out_b_oe_n_o,
  input wire logic memory_interface_clock_o,
  input wire logic memory_clock_source_ext_o,
  input wire logic [HD_W-1:0] host_port_data_pins_oe_n_o,
  input wire logic [HD_W-1:0] bus_holder_en_o,
  input wire logic host_mode_o,
  input wire logic host_word_valid_o
);
  wire unmapped = avs_address_i > mcb_pkg::ADDR_HTX;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_wait_one_cycle: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one wait cycle");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for two cycles");
  a_unmapped_resp: assert property (avs_read_i && !avs_waitrequest_o && unmapped
    |-> avs_response_o == mcb_pkg::RESP_SLVERR && avs_readdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_clock_driven_release: assert property ($fell(reset_i) |-> !memory_clock_out_b_oe_n_o)
    else $error("clock output floated at release");
  a_pins_input_release: assert property ($fell(reset_i) |-> &host_port_data_pins_oe_n_o)
    else $error("data pins driven at release");
  a_holders_on_release: assert property ($fell(reset_i) |-> &bus_holder_en_o)
    else $error("holders off at release");
  a_mode_frozen: assert property (!$past(reset_i) && !$past(reset_i, 2) |-> $stable(host_mode_o))
    else $error("pin function changed outside reset");
  a_valid_host_only: assert property (host_word_valid_o |-> host_mode_o)
    else $error("host word in gpio mode");
  a_valid_pulse: assert property (host_word_valid_o |=> !host_word_valid_o)
    else $error("word valid longer than one cycle");
  a_source_follow: assert property ($stable(memory_clock_source_select_i) [*4]
    |-> memory_clock_source_ext_o == memory_clock_source_select_i)
    else $error("clock source does not follow select");
  a_float_low: assert property (memory_clock_out_b_oe_n_o |-> !memory_clock_out_b_o)
    else $error("floated clock output not low");
  a_no_runt: assert property ($changed(memory_clock_out_b_o) |=> $stable(memory_clock_out_b_o))
    else $error("runt pulse on clock output");
  // the interface clock is the selected source pin seen through two sync flops and one output flop
  a_iface_clock: assert property ($stable(memory_clock_source_select_i) [*4]
    |-> memory_interface_clock_o == (memory_clock_source_select_i ? $past(external_memory_clock_in_i, 3)
    : $past(internal_system_clock_i, 3)))
    else $error("memory interface clock does not follow the selected source");
endmodule : mcb_pin_strap_properties
bind mcb_pin_strap mcb_pin_strap_properties #(.HD_W(HD_W)) mcb_pin_strap_properties_inst (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .internal_system_clock_i(internal_system_clock_i),
  .external_memory_clock_in_i(external_memory_clock_in_i),
  .memory_clock_source_select_i(memory_clock_source_select_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .avs_response_o(avs_response_o),
  .memory_clock_out_b_o(memory_clock_out_b_o),
  .memory_clock_out_b_oe_n_o(memory_clock_out_b_oe_n_o),
  .memory_interface_clock_o(memory_interface_clock_o),
  .memory_clock_source_ext_o(memory_clock_source_ext_o),
  .host_port_data_pins_oe_n_o(host_port_data_pins_oe_n_o),
  .bus_holder_en_o(bus_holder_en_o),
  .host_mode_o(host_mode_o),
  .host_word_valid_o(host_word_valid_o)
);
`default_nettype wire

//--- tb/mcb_host_model.sv
// host model: byte-wide multiplexed port master issuing two-byte cycles
`timescale 1ns/1ps
`default_nettype none
module mcb_host_model (
  input wire logic clk_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic drive_o,
  output logic strobe_o,
  output logic read_o
);
  initial begin
    data_o = 8'h00;
    drive_o = 1'b0;
    strobe_o = 1'b0;
    read_o = 1'b0;
  end
  // data is held well past the strobe so the synchronised sample is clean
  task send_word(input logic [15:0] w);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      data_o <= w[8*i +: 8];
      drive_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      strobe_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      strobe_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      drive_o <= 1'b0;
    end
  endtask : send_word
  // read cycle: the device drives one byte per strobe, low byte first
  task recv_word(output logic [15:0] w);
    @(posedge clk_i);
    read_o <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      repeat (6) @(posedge clk_i);
      w[8*i +: 8] = data_i;
      strobe_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      strobe_o <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
    read_o <= 1'b0;
  endtask : recv_word
endmodule : mcb_host_model
`default_nettype wire

//--- tb/mcb_pin_strap_bench.sv
// bench: strap cases, divider modes, gpio holders and host word transfers
`timescale 1ns/1ps
`default_nettype none
module mcb_pin_strap_bench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic internal_system_clock_i = 1'b0;
  logic external_memory_clock_in_i = 1'b0;
  logic memory_clock_source_select_i = 1'b0;
  logic boot_strap_pin_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] avs_response_o;
  logic memory_clock_out_b_o, memory_clock_out_b_oe_n_o, memory_interface_clock_o, memory_clock_source_ext_o;
  logic [7:0] host_port_data_pins_i, host_port_data_pins_o, host_port_data_pins_oe_n_o;
  logic [7:0] bus_holder_en_o, bus_holder_level_o, host_data;
  logic [7:0] float_q = 8'h5a;
  logic host_drive, host_strobe_i, host_read_i, host_mode_o, host_word_valid_o;
  logic [15:0] host_word_o;
  logic [31:0] rd;
  logic [1:0] rsp;
  int per;
  int sc = 0;
  int ec = 0;
  int fails = 0;
  int total_checks = 0;
  always #4 clk_i = ~clk_i;
  // source clocks: system period 8 clk, external period 12 clk
  always @(posedge clk_i) begin
    sc <= (sc + 1) % 4;
    ec <= (ec + 1) % 6;
    if (sc == 3) internal_system_clock_i <= ~internal_system_clock_i;
    if (ec == 5) external_memory_clock_in_i <= ~external_memory_clock_in_i;
    float_q <= ~float_q;
  end
  // released pins keep the holder level, or wander when the holder is off
  assign host_port_data_pins_i = (~host_port_data_pins_oe_n_o & host_port_data_pins_o)
    | (host_port_data_pins_oe_n_o & (host_drive ? host_data
    : (bus_holder_en_o & bus_holder_level_o) | (~bus_holder_en_o & float_q)));
  mcb_pin_strap #(.HD_W(8)) mcb_pin_strap_inst (.*);
  mcb_host_model mcb_host_model_inst (.clk_i(clk_i), .data_i(host_port_data_pins_i), .data_o(host_data),
    .drive_o(host_drive),
    .strobe_o(host_strobe_i), .read_o(host_read_i));
  task chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk
  task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    rsp = avs_response_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    chk(n < 50, "bus timeout");
  endtask : av
  // cycles between the second and third rising edge seen on the clock output
  task period(output int p);
    int c, a, r;
    logic prev;
    c = 0;
    a = 0;
    r = 0;
    p = 0;
    prev = memory_clock_out_b_o;
    while (r < 3 && c < 600) begin
      @(posedge clk_i);
      c++;
      if (memory_clock_out_b_o === 1'b1 && prev === 1'b0) begin
        r++;
        if (r == 2) a = c;
        if (r == 3) p = c - a;
      end
      prev = memory_clock_out_b_o;
    end
  endtask : period
  task stays_low(output logic hi);
    hi = 1'b0;
    repeat (60) @(posedge clk_i);
    repeat (100) begin
      @(posedge clk_i);
      hi = hi | memory_clock_out_b_o;
    end
  endtask : stays_low
  task do_reset(input logic strap, input logic sel);
    @(posedge clk_i);
    reset_i <= 1'b1;
    boot_strap_pin_i <= strap;
    memory_clock_source_select_i <= sel;
    repeat (8) @(posedge clk_i);
  endtask : do_reset
  task t_strap_cases;
    logic hi;
    for (int k = 0; k < 4; k++) begin
      do_reset(k[1], k[0]);
      period(per);
      chk(per == (k[0] ? 48 : 32), "clock out rate in reset");
      reset_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(host_mode_o === k[1], "pin function after release");
      chk(memory_clock_source_ext_o === k[0], "memory clock source");
      chk(host_port_data_pins_oe_n_o === 8'hff, "data pins not inputs");
      boot_strap_pin_i <= ~k[1];
      if (k == 0) begin
        stays_low(hi);
        chk(hi === 1'b0, "clock out not held low");
      end else begin
        period(per);
        if (k[0]) chk(per == 48, "external quarter rate");
        else chk(per == 32, "system quarter rate");
      end
      chk(host_mode_o === k[1], "pin function changed after release");
    end
  endtask : t_strap_cases
  task t_divider;
    logic hi;
    do_reset(1'b1, 1'b0);
    reset_i <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      av(1'b1, mcb_pkg::ADDR_CTRL2, {28'h0, 2'(k), mcb_pkg::MCB_MODE_TOGGLE});
      repeat (80) @(posedge clk_i);
      period(per);
      chk(per == (8 << k), "divided clock period");
    end
    av(1'b1, mcb_pkg::ADDR_CTRL2, {28'h0, mcb_pkg::MCB_DIV1, mcb_pkg::MCB_MODE_HOLD});
    stays_low(hi);
    chk(hi === 1'b0, "hold mode toggles");
    av(1'b1, mcb_pkg::ADDR_CTRL2, {28'h0, mcb_pkg::MCB_DIV1, mcb_pkg::MCB_MODE_HIZ});
    repeat (40) @(posedge clk_i);
    chk(memory_clock_out_b_oe_n_o === 1'b1, "clock output not floated");
    av(1'b0, mcb_pkg::ADDR_CTRL2, 32'h0);
    chk(rd[3:0] === {mcb_pkg::MCB_DIV1, mcb_pkg::MCB_MODE_HIZ}, "control readback");
  endtask : t_divider
  task t_gpio;
    do_reset(1'b0, 1'b0);
    reset_i <= 1'b0;
    av(1'b0, mcb_pkg::ADDR_XBUS, 32'h0);
    chk(rd[7:0] === mcb_pkg::XBUS_RESET, "holder enables after reset");
    av(1'b0, mcb_pkg::ADDR_GDIR, 32'h0);
    chk(rd[7:0] === mcb_pkg::GDIR_RESET, "gpio direction after reset");
    av(1'b1, mcb_pkg::ADDR_GOUT, 32'ha5);
    av(1'b1, mcb_pkg::ADDR_GDIR, 32'hff);
    repeat (3) @(posedge clk_i);
    chk(host_port_data_pins_oe_n_o === 8'h00 && host_port_data_pins_o === 8'ha5, "gpio drive");
    av(1'b1, mcb_pkg::ADDR_GDIR, 32'h0);
    repeat (10) @(posedge clk_i);
    av(1'b0, mcb_pkg::ADDR_STAT, 32'h0);
    chk(bus_holder_level_o === 8'ha5 && rd[15:8] === 8'ha5, "held level lost");
    av(1'b1, mcb_pkg::ADDR_XBUS, 32'h0f);
    repeat (2) @(posedge clk_i);
    chk(bus_holder_en_o === 8'h0f, "holder enable switch");
    av(1'b0, 8'h40, 32'h0);
    chk(rsp === mcb_pkg::RESP_SLVERR && rd === 32'h0, "unmapped read");
  endtask : t_gpio
  task t_host;
    int n;
    logic [15:0] hw;
    do_reset(1'b1, 1'b1);
    reset_i <= 1'b0;
    n = 0;
    fork
      mcb_host_model_inst.send_word(16'hbeef);
      while (host_word_valid_o !== 1'b1 && n < 200) begin
        @(posedge clk_i);
        n++;
      end
    join
    chk(n < 200 && host_word_o === 16'hbeef, "assembled host word");
    av(1'b0, mcb_pkg::ADDR_HRX, 32'h0);
    chk(rd[15:0] === 16'hbeef, "host word register");
    av(1'b0, mcb_pkg::ADDR_STAT, 32'h0);
    chk(rd[0] === 1'b1, "multiplexed host mode");
    av(1'b1, mcb_pkg::ADDR_HTX, 32'h1234);
    mcb_host_model_inst.recv_word(hw);
    chk(hw === 16'h1234, "host read bytes");
    chk(host_word_o === 16'h1234, "host read word");
  endtask : t_host
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    t_strap_cases();
    t_divider();
    t_gpio();
    t_host();
    test_done();
  end
  initial begin
    #(8 * 12000);
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done();
  end
endmodule : mcb_pin_strap_bench
`default_nettype wire
